// File: pq_regs_pkg.sv
// package for the dip, swell, no-load and channel source register bank
package pq_regs_pkg;
	// ------------------------------------------------------------
	// register offsets (word addresses on the register port)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_DIP_THRESHOLD = 12'h410;
	localparam logic [11:0] ADDR_DIP_VALUE_A = 12'h411;
	localparam logic [11:0] ADDR_DIP_VALUE_B = 12'h412;
	localparam logic [11:0] ADDR_DIP_VALUE_C = 12'h413;
	localparam logic [11:0] ADDR_SWELL_THRESHOLD = 12'h414;
	localparam logic [11:0] ADDR_SWELL_VALUE_A = 12'h415;
	localparam logic [11:0] ADDR_SWELL_VALUE_B = 12'h416;
	localparam logic [11:0] ADDR_SWELL_VALUE_C = 12'h417;
	localparam logic [11:0] ADDR_PHASE_NOLOAD = 12'h41f;
	localparam logic [11:0] ADDR_CHANNEL_SOURCE = 12'h424;
	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int LEVEL_W = 24;
	localparam int SAMPLE_W = 24;
	localparam int NUM_CH = 7;
	localparam int SEL_W = 3;
	localparam int NOLOAD_W = 18;
	localparam int PHASE_NL_STRIDE = 6;
	localparam int FUND_NL_OFS = 3;
	localparam int FIFO_DEPTH = 4;
	localparam logic [23:0] DIP_THRESHOLD_RST = 24'h000000;
	localparam logic [23:0] DIP_VALUE_RST = 24'h7fffff;
	localparam logic [23:0] SWELL_THRESHOLD_RST = 24'hffffff;
	localparam logic [23:0] SWELL_VALUE_RST = 24'h000000;
	localparam logic [17:0] NOLOAD_RST = 18'h00000;
	// ------------------------------------------------------------
	// channel source codes, channel index equals its own code
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_IA = 3'b000,
		SRC_IB = 3'b001,
		SRC_IC = 3'b010,
		SRC_IN = 3'b011,
		SRC_VA = 3'b100,
		SRC_VB = 3'b101,
		SRC_VC = 3'b110,
		SRC_OWN = 3'b111
	} source_sel_e;
	// selector register layout, field i at bits [3i+2:3i]
	typedef struct packed {
		logic [10:0] reserved;
		source_sel_e volt_c_source_sel;
		source_sel_e volt_b_source_sel;
		source_sel_e volt_a_source_sel;
		source_sel_e cur_n_source_sel;
		source_sel_e cur_c_source_sel;
		source_sel_e cur_b_source_sel;
		source_sel_e cur_a_source_sel;
	} source_select_s;
	// per-phase no-load flags, order within a phase as in the status word
	typedef struct packed {
		logic fund_apparent;
		logic fund_reactive;
		logic fund_active;
		logic total_apparent;
		logic total_reactive;
		logic total_active;
	} phase_noload_s;
	// register port request
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_s;
	// one converter sample set, all seven channels
	typedef struct packed {
		logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
	} sample_set_s;
endpackage

// File: sample_fifo.sv
// small valid/ready fifo for the redirected sample stream
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 168,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
	} fifo_state_s;
	fifo_state_s st_reg;
	fifo_state_s st_next;
	logic push;
	logic pop;

	// full and empty come straight from the occupancy count
	assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
	assign out_valid = (st_reg.count != '0);
	assign out_data = st_reg.mem[st_reg.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer wrap uses DEPTH so a non power of two still works
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wptr] = in_data;
			st_next.wptr = (st_reg.wptr == AW'(DEPTH-1)) ? '0 : st_reg.wptr + 1'b1;
		end
		if (pop) begin
			st_next.rptr = (st_reg.rptr == AW'(DEPTH-1)) ? '0 : st_reg.rptr + 1'b1;
		end
		st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	// register the state; memory contents need no reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg.wptr <= '0;
			st_reg.rptr <= '0;
			st_reg.count <= '0;
		end else begin
			st_reg <= st_next;
		end
		if (!rst) begin
			st_reg.mem <= st_next.mem;
		end
	end
endmodule // sample_fifo

// File: pq_dip_swell_noload_regs.sv
// dip/swell capture, no-load status and channel source redirect register bank
`timescale 1ns/1ps
module pq_dip_swell_noload_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// host register port
	input wire pq_regs_pkg::reg_req_s reg_req,
	output logic [31:0] reg_rdata,
	output logic reg_rdata_valid,
	// measured voltage rms-half per phase, with update strobe
	input wire logic [pq_regs_pkg::LEVEL_W-1:0] vrms_half_a,
	input wire logic [pq_regs_pkg::LEVEL_W-1:0] vrms_half_b,
	input wire logic [pq_regs_pkg::LEVEL_W-1:0] vrms_half_c,
	input wire logic vrms_half_update,
	// no-load indications from the energy engines
	input wire pq_regs_pkg::phase_noload_s noload_pa,
	input wire pq_regs_pkg::phase_noload_s noload_pb,
	input wire pq_regs_pkg::phase_noload_s noload_pc,
	// event enables
	input wire logic [2:0] dip_event_en,
	input wire logic total_active_noload_event_en,
	output logic event_n,
	// converter samples in
	input wire pq_regs_pkg::sample_set_s adc_samples,
	input wire logic adc_valid,
	output logic adc_ready,
	// redirected samples out to the measurement channels
	output pq_regs_pkg::sample_set_s chan_samples,
	output logic chan_valid,
	input wire logic chan_ready
);
	import pq_regs_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LEVEL_W-1:0] dip_threshold_level;
		logic [2:0][LEVEL_W-1:0] dip_value;
		logic [LEVEL_W-1:0] swell_threshold_level;
		logic [2:0][LEVEL_W-1:0] swell_value;
		logic [NOLOAD_W-1:0] noload;
		logic [2:0] in_dip;
		source_select_s src_sel;
		logic [31:0] rdata;
		logic rdata_valid;
		logic event_n;
		sample_set_s routed;
		logic routed_valid;
	} bank_state_s;
	bank_state_s st_reg;
	bank_state_s st_next;
	logic [2:0][LEVEL_W-1:0] vrms;
	logic [NUM_CH-1:0][SEL_W-1:0] sel_vec;
	logic fifo_in_ready;
	logic stall;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// pad a 24-bit field to a register word, upper byte reads zero
	function automatic logic [31:0] word24(input logic [LEVEL_W-1:0] v);
		return {8'h00, v};
	endfunction

	// pick one channel's source sample by selector code
	function automatic logic [SAMPLE_W-1:0] route(input sample_set_s s, input source_sel_e sel,
			input int own);
		logic [SAMPLE_W-1:0] r;
		r = s.ch[own];
		if (sel != SRC_OWN) begin
			r = s.ch[sel];
		end
		return r;
	endfunction

	assign vrms = {vrms_half_c, vrms_half_b, vrms_half_a};
	assign sel_vec = {st_reg.src_sel.volt_c_source_sel, st_reg.src_sel.volt_b_source_sel,
		st_reg.src_sel.volt_a_source_sel, st_reg.src_sel.cur_n_source_sel,
		st_reg.src_sel.cur_c_source_sel, st_reg.src_sel.cur_b_source_sel,
		st_reg.src_sel.cur_a_source_sel};
	// the routing stage stalls while its output is held and the fifo is full
	assign stall = st_reg.routed_valid && !fifo_in_ready;
	assign adc_ready = !stall;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rdata_valid = 1'b0;
		// host writes; read-only and reserved bits are simply not stored
		if (reg_req.wr_en) begin
			unique case (reg_req.addr)
				ADDR_DIP_THRESHOLD: begin
					st_next.dip_threshold_level = reg_req.wdata[LEVEL_W-1:0];
				end
				ADDR_SWELL_THRESHOLD: begin
					st_next.swell_threshold_level = reg_req.wdata[LEVEL_W-1:0];
				end
				ADDR_CHANNEL_SOURCE: begin
					st_next.src_sel = reg_req.wdata;
					st_next.src_sel.reserved = '0;
				end
				default: begin
				end
			endcase
		end
		// host reads, data one cycle later; unmapped addresses read zero
		if (reg_req.rd_en) begin
			st_next.rdata_valid = 1'b1;
			unique case (reg_req.addr)
				ADDR_DIP_THRESHOLD: st_next.rdata = word24(st_reg.dip_threshold_level);
				ADDR_DIP_VALUE_A: st_next.rdata = word24(st_reg.dip_value[0]);
				ADDR_DIP_VALUE_B: st_next.rdata = word24(st_reg.dip_value[1]);
				ADDR_DIP_VALUE_C: st_next.rdata = word24(st_reg.dip_value[2]);
				ADDR_SWELL_THRESHOLD: st_next.rdata = word24(st_reg.swell_threshold_level);
				ADDR_SWELL_VALUE_A: st_next.rdata = word24(st_reg.swell_value[0]);
				ADDR_SWELL_VALUE_B: st_next.rdata = word24(st_reg.swell_value[1]);
				ADDR_SWELL_VALUE_C: st_next.rdata = word24(st_reg.swell_value[2]);
				ADDR_PHASE_NOLOAD: st_next.rdata = {14'h0000, st_reg.noload};
				ADDR_CHANNEL_SOURCE: st_next.rdata = st_reg.src_sel;
				default: st_next.rdata = 32'h00000000;
			endcase
		end
		// dip and swell detection on each fresh rms-half value
		if (vrms_half_update) begin
			for (int p = 0; p < 3; p++) begin
				st_next.in_dip[p] = (vrms[p] < st_reg.dip_threshold_level);
				if (vrms[p] < st_reg.dip_threshold_level) begin
					st_next.dip_value[p] = vrms[p];
				end
				if (vrms[p] > st_reg.swell_threshold_level) begin
					st_next.swell_value[p] = vrms[p];
				end
			end
		end
		// no-load status mirrors the engines, phase a low, stride six
		st_next.noload = {noload_pc, noload_pb, noload_pa};
		// event output low while any enabled cause is present
		st_next.event_n = !((|(st_reg.in_dip & dip_event_en))
			|| (total_active_noload_event_en && (noload_pa.total_active
			|| noload_pb.total_active || noload_pc.total_active)));
		// routing stage: loads a new sample set when not stalled
		if (!stall) begin
			st_next.routed_valid = adc_valid;
			if (adc_valid) begin
				for (int c = 0; c < NUM_CH; c++) begin
					st_next.routed.ch[c] = route(adc_samples, source_sel_e'(sel_vec[c]), c);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg.dip_threshold_level <= DIP_THRESHOLD_RST;
			st_reg.dip_value <= {3{DIP_VALUE_RST}};
			st_reg.swell_threshold_level <= SWELL_THRESHOLD_RST;
			st_reg.swell_value <= {3{SWELL_VALUE_RST}};
			st_reg.noload <= NOLOAD_RST;
			st_reg.in_dip <= 3'h0;
			st_reg.src_sel <= '{reserved: 11'h000, default: SRC_OWN};
			st_reg.rdata <= 32'h00000000;
			st_reg.rdata_valid <= 1'b0;
			st_reg.event_n <= 1'b1;
			st_reg.routed <= '0;
			st_reg.routed_valid <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rdata_valid = st_reg.rdata_valid;
	assign event_n = st_reg.event_n;

	// ------------------------------------------------------------
	// output buffering of routed samples
	// ------------------------------------------------------------
	// the fifo absorbs short stalls of the measurement channels
	sample_fifo #(
		.WIDTH(NUM_CH*SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(st_reg.routed_valid),
		.in_ready(fifo_in_ready),
		.in_data(st_reg.routed),
		.out_valid(chan_valid),
		.out_ready(chan_ready),
		.out_data(chan_samples)
	);
endmodule // pq_dip_swell_noload_regs

// File: pq_regs_props.sv
// assertions on the ports of the dip, swell, no-load and source register bank
`timescale 1ns/1ps
module pq_regs_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire pq_regs_pkg::reg_req_s reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rdata_valid,
	// status and events
	input wire pq_regs_pkg::phase_noload_s noload_pa,
	input wire pq_regs_pkg::phase_noload_s noload_pb,
	input wire pq_regs_pkg::phase_noload_s noload_pc,
	input wire logic [2:0] dip_event_en,
	input wire logic total_active_noload_event_en,
	input wire logic event_n,
	// sample stream out
	input wire pq_regs_pkg::sample_set_s chan_samples,
	input wire logic chan_valid,
	input wire logic chan_ready
);
	import pq_regs_pkg::*;
	// ----
	// port relations
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic rd = reg_req.rd_en;
	property p_dip_upper;
		rd && reg_req.addr == ADDR_DIP_THRESHOLD |=> reg_rdata[31:24] == 8'h00;
	endproperty
	a_dip_upper: assert property (p_dip_upper) else $error("dip threshold upper byte set");
	property p_nl_upper;
		rd && reg_req.addr == ADDR_PHASE_NOLOAD |=> reg_rdata[31:18] == 14'h0000;
	endproperty
	a_nl_upper: assert property (p_nl_upper) else $error("no-load upper bits set");
	property p_sel_upper;
		rd && reg_req.addr == ADDR_CHANNEL_SOURCE |=> reg_rdata[31:21] == 11'h000;
	endproperty
	a_sel_upper: assert property (p_sel_upper) else $error("selector upper bits set");
	// status word is the inputs two edges before the answer
	property p_nl_map;
		rd && reg_req.addr == ADDR_PHASE_NOLOAD && !$past(rst) |=>
			reg_rdata[17:0] == {$past(noload_pc, 2), $past(noload_pb, 2), $past(noload_pa, 2)};
	endproperty
	a_nl_map: assert property (p_nl_map) else $error("no-load bit map wrong");
	property p_nl_event;
		total_active_noload_event_en && (noload_pa.total_active || noload_pb.total_active
			|| noload_pc.total_active) |=> !event_n;
	endproperty
	a_nl_event: assert property (p_nl_event) else $error("no-load event missing");
	property p_no_event;
		(dip_event_en == 3'b000 && !total_active_noload_event_en) [*3] |-> event_n;
	endproperty
	a_no_event: assert property (p_no_event) else $error("event without enable");
	property p_hold;
		chan_valid && !chan_ready |=> chan_valid && $stable(chan_samples);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled sample changed");
	property p_answer;
		!$past(rst) |-> reg_rdata_valid == $past(rd);
	endproperty
	a_answer: assert property (p_answer) else $error("read answer timing wrong");
	c_nl_read: cover property (rd && reg_req.addr == ADDR_PHASE_NOLOAD);
	c_event: cover property (!event_n);
	c_pop: cover property (chan_valid && chan_ready);
endmodule // pq_regs_props

// File: pq_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
module pq_host_model (
	// clock
	input wire logic core_clk,
	// register port
	output pq_regs_pkg::reg_req_s reg_req,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rdata_valid
);
	import pq_regs_pkg::*;
	initial reg_req = '0;
	// write held for one taking edge, then the data lines show junk;
	// an idle edge follows so back-to-back calls never drive the port twice in one step
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk) #1;
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
		@(posedge core_clk) #1;
	endtask
	// read: the answer stands only in the cycle after the taking edge, so it is
	// looked at right after that edge; bounded wait, then one idle edge
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output bit ok);
		reg_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk) #1;
		reg_req <= '{1'b0, 1'b0, ~a, 32'hffffffff};
		ok = 0;
		d = 32'h0;
		for (int i = 0; i < 4 && !ok; i++) begin
			ok = reg_rdata_valid;
			d = reg_rdata;
			@(posedge core_clk) #1;
		end
	endtask
endmodule // pq_host_model

// File: tb_pq_dip_swell_noload_regs.sv
// self-checking bench for the dip, swell, no-load and source register bank
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_pq_dip_swell_noload_regs;
	import pq_regs_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	reg_req_s reg_req;
	logic [31:0] reg_rdata, rd_d, seed = 32'hf33e, sel;
	logic reg_rdata_valid, vrms_half_update = 0, total_active_noload_event_en = 0, event_n;
	logic [23:0] v[3], dipv[3], swv[3], thr_d = 24'h400000, thr_s = 24'h600000;
	phase_noload_s nl[3];
	logic [2:0] dip_event_en = 0, in_dip = 0;
	sample_set_s adc_samples, chan_samples, exp_s, exp_q[$];
	logic adc_valid = 0, adc_ready, chan_valid, chan_ready = 0, took = 0;
	int miscompares = 0, checks_done = 0;
	bit ok;
	logic [11:0] ra[11] = '{12'h410, 12'h411, 12'h412, 12'h413, 12'h414, 12'h415, 12'h416,
		12'h417, 12'h41f, 12'h424, 12'h418};
	logic [31:0] rv[11] = '{32'h0, 32'h7fffff, 32'h7fffff, 32'h7fffff, 32'hffffff, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h1fffff, 32'h0};
	pq_dip_swell_noload_regs pq_dip_swell_noload_regs_i (.core_clk, .rst, .reg_req, .reg_rdata,
		.reg_rdata_valid, .vrms_half_a(v[0]), .vrms_half_b(v[1]), .vrms_half_c(v[2]),
		.vrms_half_update, .noload_pa(nl[0]), .noload_pb(nl[1]), .noload_pc(nl[2]),
		.dip_event_en, .total_active_noload_event_en, .event_n, .adc_samples, .adc_valid,
		.adc_ready, .chan_samples, .chan_valid, .chan_ready);
	pq_host_model pq_host_model_i (.core_clk, .reg_req, .reg_rdata, .reg_rdata_valid);
	// ----
	// clock, helpers and main sequence
	// ----
	initial forever #20 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected routing, code 111 keeps the channel's own data
	function automatic sample_set_s route(sample_set_s s);
		sample_set_s r;
		for (int i = 0; i < NUM_CH; i++) begin
			r.ch[i] = sel[3*i+:3] == 3'b111 ? s.ch[i] : s.ch[sel[3*i+:3]];
		end
		return r;
	endfunction
	task automatic test_done();
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		pq_host_model_i.rd(a, rd_d, ok);
		if (!ok) begin
			miscompares++;
			test_done();
		end
		`CHK(rd_d, e)
	endtask
	// one rms update on all phases; event is looked at two cycles on
	task automatic upd();
		dip_event_en = 3'(rnd());
		for (int p = 0; p < 3; p++) begin
			v[p] = 24'(rnd());
			in_dip[p] = v[p] < thr_d;
			if (v[p] < thr_d) dipv[p] = v[p];
			if (v[p] > thr_s) swv[p] = v[p];
		end
		vrms_half_update = 1;
		@(posedge core_clk) #1;
		vrms_half_update = 0;
		@(posedge core_clk) #1;
		`CHK(event_n, ~|(in_dip & dip_event_en))
	endtask
	// one stream cycle; an offered set keeps valid and data up until it is taken
	task automatic cyc(input bit send, input bit rdy);
		if (!adc_valid || took) begin
			adc_samples = 168'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
			adc_valid = send;
		end
		chan_ready = rdy;
		#4;
		took = adc_valid && adc_ready;
		if (chan_valid && chan_ready) begin
			exp_s = exp_q.pop_front();
			`CHK(chan_samples, exp_s)
		end
		@(posedge core_clk) #1;
		if (took) exp_q.push_back(route(adc_samples));
	endtask
	initial begin
		v = '{24'h0, 24'h0, 24'h0};
		nl = '{6'h0, 6'h0, 6'h0};
		dipv = '{24'h7fffff, 24'h7fffff, 24'h7fffff};
		swv = '{24'h0, 24'h0, 24'h0};
		adc_samples = '0;
		repeat (20) @(posedge core_clk);
		#1 rst = 0;
		for (int i = 0; i < 11; i++) rchk(ra[i], rv[i]);
		for (int i = 0; i < 11; i++) pq_host_model_i.wr(ra[i], 32'hffffffff);
		for (int i = 0; i < 11; i++) rchk(ra[i], i == 0 || i == 4 ? 32'hffffff : rv[i]);
		pq_host_model_i.wr(12'h410, {8'hff, thr_d});
		pq_host_model_i.wr(12'h414, {8'hff, thr_s});
		repeat (8) begin
			upd();
			for (int p = 0; p < 3; p++) begin
				rchk(12'(12'h411 + p), {8'h0, dipv[p]});
				rchk(12'(12'h415 + p), {8'h0, swv[p]});
			end
		end
		dip_event_en = 0;
		total_active_noload_event_en = 1;
		repeat (8) begin
			sel = rnd() & rnd();
			for (int p = 0; p < 3; p++) nl[p] = sel[6*p+:6];
			repeat (2) @(posedge core_clk) #1;
			`CHK(event_n, !(sel[0] | sel[6] | sel[12]))
			rchk(12'h41f, {14'h0, sel[17:0]});
		end
		// two passes cover every code, a third is random
		for (int k = 0; k < 3; k++) begin
			sel = rnd();
			for (int i = 0; i < NUM_CH && k < 2; i++) sel[3*i+:3] = 3'(i + k);
			pq_host_model_i.wr(12'h424, sel);
			sel &= 32'h1fffff;
			rchk(12'h424, sel);
			for (int i = 0; i < 12; i++) cyc(1, 0);
			`CHK(adc_ready, 1'b0)
			for (int i = 0; i < 200; i++) cyc(rnd() % 3 != 0, rnd() % 3 != 0);
			for (int i = 0; i < 20; i++) cyc(0, 1);
			`CHK(exp_q.size(), 0)
		end
		test_done();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		miscompares++;
		test_done();
	end
endmodule // tb_pq_dip_swell_noload_regs
bind pq_dip_swell_noload_regs pq_regs_props pq_regs_props_i (.*);
